// [aps_pin_func_select.sv]
// Purpose: function select for the auxiliary control bus and primary port
// Assumes: usb and uart engine signals share mclk; pins are asynchronous
// Notes: pin outputs are registered, one cycle after their cause
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns

// Summary of operation
// - line driver enable spans one bit before start to one bit after stop
// - power_enable_n low once configured, high while suspended
// - tx_activity_led_n pulses low while transmitting
// - rx_activity_led_n pulses low while receiving
// - activity_led_n pulses low on transmit or receive
// - suspend_indicator_n low exactly while suspended
// - divided clocks at 30, 15, 7.5 MHz, stopped in suspend
// - bit-bang only on pins 5,6,8,9; clocks and high on 0,5,6,8,9
// - inputs pulled up, or weakly down in suspend when option set
// - pin functions come from the function select registers written over the bus
// - without configuration every auxiliary pin is a pulled-up input
// - primary port drives txd, rts, dtr; reads rxd, cts, dsr, dcd, ri
// - suspended with remote wakeup, low ring indicator requests resume
// - primary port runs in uart configuration after reset
module aps_pin_func_select
  import aps_pkg::*;
#(
  parameter int LED_HOLD_CYC = LED_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic usbSuspend,
  input wire logic usbConfigured,
  output logic usbResumeReq,
  input wire logic uartTxPending,
  input wire logic uartTxBusy,
  input wire logic uartRxBusy,
  output logic uartTxGo,
  input wire logic uartTxd,
  input wire logic uartRtsN,
  input wire logic uartDtrN,
  output logic uartRxd,
  output logic uartCtsN,
  output logic uartDsrN,
  output logic uartDcdN,
  output logic uartRiN,
  input wire logic [7:0] priPortIn,
  output logic [7:0] priPortOut,
  output logic [7:0] priPortOe,
  input wire logic [AUX_PINS-1:0] auxIn,
  output logic [AUX_PINS-1:0] auxOut,
  output logic [AUX_PINS-1:0] auxOe,
  output logic [AUX_PINS-1:0] auxPullUp,
  output logic [AUX_PINS-1:0] auxPullDown
);

  // =====================================================================
  // state
  typedef struct packed {
    logic [AUX_PINS-1:0][3:0] funcSel;
    logic [2:0] opts;
    logic [15:0] bitPeriod;
    logic [AUX_PINS-1:0] bbOut;
    logic [AUX_PINS-1:0] bbDir;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdData;
    aps_ld_state_t ldState;
    logic [15:0] ldCnt;
    logic sawBusy;
    logic [AUX_PINS-1:0] auxS1;
    logic [AUX_PINS-1:0] auxS2;
    logic [4:0] priS1;
    logic [4:0] priS2;
    logic [AUX_PINS-1:0] auxOut;
    logic [AUX_PINS-1:0] auxOe;
    logic [AUX_PINS-1:0] auxPu;
    logic [AUX_PINS-1:0] auxPd;
    logic [7:0] priOut;
    logic [7:0] priOe;
    logic resumeReq;
  } aps_main_state_t;

  aps_main_state_t s;
  aps_main_state_t n;

  logic txLedN;
  logic rxLedN;
  logic actLedN;
  logic clkHalf;
  logic clkQuarter;
  logic clkEighth;
  logic clkRun;
  logic lineDrvEn;
  logic accept;

  // =====================================================================
  // helpers
  assign clkRun = ~usbSuspend;
  assign lineDrvEn = (s.ldState != LD_IDLE);
  assign accept = hsel & hready & htrans[1];

  aps_clk_gen #(.OUT_KHZ(HALF_CLK_KHZ)) clkHalfGen (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(clkRun),
    .clkOut(clkHalf)
  );

  aps_clk_gen #(.OUT_KHZ(QUARTER_CLK_KHZ)) clkQuarterGen (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(clkRun),
    .clkOut(clkQuarter)
  );

  aps_clk_gen #(.OUT_KHZ(EIGHTH_CLK_KHZ)) clkEighthGen (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(clkRun),
    .clkOut(clkEighth)
  );

  aps_led_pulse #(.HOLD_CYC(LED_HOLD_CYC)) tx_activity_led_n (
    .mclk(mclk),
    .rst_n(rst_n),
    .activity(uartTxBusy),
    .ledN(txLedN)
  );

  aps_led_pulse #(.HOLD_CYC(LED_HOLD_CYC)) rx_activity_led_n (
    .mclk(mclk),
    .rst_n(rst_n),
    .activity(uartRxBusy),
    .ledN(rxLedN)
  );

  aps_led_pulse #(.HOLD_CYC(LED_HOLD_CYC)) actLed (
    .mclk(mclk),
    .rst_n(rst_n),
    .activity(uartTxBusy | uartRxBusy),
    .ledN(actLedN)
  );

  // legal function for one pin, else the pulled-up input
  function automatic aps_func_t effFunc(input logic [3:0] sel,
                                        input int pin,
                                        input logic cfgValid);
    aps_func_t f;
    f = aps_func_t'(sel);
    if (!cfgValid) begin
      f = FN_INPUT_PU;
    end else if (sel > FN_BITBANG) begin
      f = FN_INPUT_PU;
    end else if (sel == FN_BITBANG && !BITBANG_MASK[pin]) begin
      f = FN_INPUT_PU;
    end else if ((sel == FN_CLK_HALF || sel == FN_CLK_QUARTER ||
                  sel == FN_CLK_EIGHTH || sel == FN_DRIVE_HIGH) &&
                 !CLK_CAPABLE_MASK[pin]) begin
      f = FN_INPUT_PU;
    end
    return f;
  endfunction

  // =====================================================================
  // next state
  always_comb begin
    logic pullDn;
    logic [31:0] rd;
    aps_func_t f;
    pullDn = 1'b0;
    rd = 32'h00000000;
    f = FN_INPUT_PU;
    n = s;

    // bus write in data phase, then read mux on updated values
    n.wrPend = accept & hwrite;
    if (accept) begin
      n.wrAddr = haddr[7:0];
    end
    if (s.wrPend) begin
      unique case (s.wrAddr)
        REG_FUNC_LO: n.funcSel[7:0] = hwdata;
        REG_FUNC_HI: n.funcSel[9:8] = hwdata[7:0];
        REG_OPTIONS: n.opts = hwdata[2:0];
        REG_BIT_PERIOD: n.bitPeriod = hwdata[15:0];
        REG_BB_OUT: n.bbOut = hwdata[AUX_PINS-1:0];
        REG_BB_DIR: n.bbDir = hwdata[AUX_PINS-1:0];
        default: ;
      endcase
    end
    unique case (haddr[7:0])
      REG_FUNC_LO: rd = n.funcSel[7:0];
      REG_FUNC_HI: rd = {24'h000000, n.funcSel[9:8]};
      REG_OPTIONS: rd = {29'h00000000, n.opts};
      REG_BIT_PERIOD: rd = {16'h0000, n.bitPeriod};
      REG_BB_OUT: rd = {22'h000000, n.bbOut};
      REG_BB_DIR: rd = {22'h000000, n.bbDir};
      REG_STATUS: begin
        rd[STAT_SUSPEND] = usbSuspend;
        rd[STAT_CONFIGURED] = usbConfigured;
        rd[STAT_LINE_DRV] = lineDrvEn;
        rd[STAT_RESUME] = s.resumeReq;
        rd[STAT_PRI_IN_LSB +: 5] = s.priS2;
        rd[STAT_AUX_IN_LSB +: AUX_PINS] = s.auxS2;
      end
      default: rd = 32'h00000000;
    endcase
    if (accept && !hwrite) begin
      n.rdData = rd;
    end

    // line driver enable sequencing around each frame
    unique case (s.ldState)
      LD_IDLE: begin
        if (uartTxPending) begin
          n.ldState = LD_LEAD;
          n.ldCnt = 16'h0001;
        end
      end
      LD_LEAD: begin
        if (s.ldCnt >= s.bitPeriod) begin
          n.ldState = LD_SEND;
          n.sawBusy = 1'b0;
        end else begin
          n.ldCnt = s.ldCnt + 16'h0001;
        end
      end
      LD_SEND: begin
        if (uartTxBusy) begin
          n.sawBusy = 1'b1;
        end else if (s.sawBusy && !uartTxPending) begin
          n.ldState = LD_TRAIL;
          n.ldCnt = 16'h0001;
        end else if (s.sawBusy) begin
          n.sawBusy = 1'b0;
        end
      end
      LD_TRAIL: begin
        if (uartTxPending) begin
          n.ldState = LD_LEAD;
          n.ldCnt = 16'h0001;
        end else if (s.ldCnt >= s.bitPeriod) begin
          n.ldState = LD_IDLE;
        end else begin
          n.ldCnt = s.ldCnt + 16'h0001;
        end
      end
    endcase

    // pin synchronisers
    n.auxS1 = auxIn;
    n.auxS2 = s.auxS1;
    n.priS1 = {priPortIn[PRI_RI], priPortIn[PRI_DCD], priPortIn[PRI_DSR],
               priPortIn[PRI_CTS], priPortIn[PRI_RXD]};
    n.priS2 = s.priS1;

    // primary port in uart configuration
    n.priOe = UART_OE_MASK;
    n.priOut = 8'h00;
    n.priOut[PRI_TXD] = uartTxd;
    n.priOut[PRI_RTS] = uartRtsN;
    n.priOut[PRI_DTR] = uartDtrN;
    n.resumeReq = usbSuspend & s.opts[OPT_REMOTE_WAKE] &
                  ~s.priS2[4];

    // auxiliary pin functions
    pullDn = usbSuspend & s.opts[OPT_SUSP_PULLDOWN];
    for (int i = 0; i < AUX_PINS; i++) begin
      f = effFunc(s.funcSel[i], i, s.opts[OPT_CFG_VALID]);
      n.auxOe[i] = 1'b1;
      n.auxOut[i] = 1'b0;
      n.auxPu[i] = 1'b0;
      n.auxPd[i] = 1'b0;
      unique case (f)
        FN_LINE_DRV: n.auxOut[i] = lineDrvEn;
        FN_PWR_EN: n.auxOut[i] = ~(usbConfigured & ~usbSuspend);
        FN_TX_LED: n.auxOut[i] = txLedN;
        FN_RX_LED: n.auxOut[i] = rxLedN;
        FN_ACT_LED: n.auxOut[i] = actLedN;
        FN_SUSPEND: n.auxOut[i] = ~usbSuspend;
        FN_CLK_HALF: n.auxOut[i] = clkHalf;
        FN_CLK_QUARTER: n.auxOut[i] = clkQuarter;
        FN_CLK_EIGHTH: n.auxOut[i] = clkEighth;
        FN_DRIVE_HIGH: n.auxOut[i] = 1'b1;
        FN_DRIVE_LOW: n.auxOut[i] = 1'b0;
        FN_BITBANG: begin
          n.auxOe[i] = s.bbDir[i];
          n.auxOut[i] = s.bbOut[i];
          n.auxPu[i] = ~s.bbDir[i] & ~pullDn;
          n.auxPd[i] = ~s.bbDir[i] & pullDn;
        end
        default: begin
          n.auxOe[i] = 1'b0;
          n.auxPu[i] = ~pullDn;
          n.auxPd[i] = pullDn;
        end
      endcase
    end
  end

  // =====================================================================
  // registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '0;
      s.funcSel <= {AUX_PINS{FN_INPUT_PU}};
      s.opts <= OPTIONS_RST;
      s.bitPeriod <= BIT_PERIOD_RST;
      s.bbOut <= BB_RST;
      s.bbDir <= BB_RST;
      s.ldState <= LD_IDLE;
      s.auxPu <= {AUX_PINS{1'b1}};
      s.priOe <= UART_OE_MASK;
      s.priOut <= UART_OE_MASK;
    end else begin
      s <= n;
    end
  end

  // =====================================================================
  // outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdData;
  assign uartTxGo = (s.ldState == LD_SEND);
  assign usbResumeReq = s.resumeReq;
  assign uartRxd = s.priS2[0];
  assign uartCtsN = s.priS2[1];
  assign uartDsrN = s.priS2[2];
  assign uartDcdN = s.priS2[3];
  assign uartRiN = s.priS2[4];
  assign priPortOut = s.priOut;
  assign priPortOe = s.priOe;
  assign auxOut = s.auxOut;
  assign auxOe = s.auxOe;
  assign auxPullUp = s.auxPu;
  assign auxPullDown = s.auxPd;

endmodule

// [aps_pkg.sv]
// Purpose: shared constants and types for the auxiliary pin function select
// Assumes: 125 MHz mclk, 32-bit AHB-Lite register access
// Notes: offsets are byte addresses, one aligned word per register
package aps_pkg;

  // =====================================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MCLK_KHZ = 125000;
  localparam int HALF_CLK_KHZ = 30000;
  localparam int QUARTER_CLK_KHZ = 15000;
  localparam int EIGHTH_CLK_KHZ = 7500;
  localparam int LED_PULSE_NS = 20000;
  localparam int LED_PULSE_CYC =
    (LED_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // =====================================================================
  // pins
  localparam int AUX_PINS = 10;
  localparam logic [9:0] CLK_CAPABLE_MASK = 10'h361;
  localparam logic [9:0] BITBANG_MASK = 10'h360;
  localparam int PRI_TXD = 0;
  localparam int PRI_RXD = 1;
  localparam int PRI_RTS = 2;
  localparam int PRI_CTS = 3;
  localparam int PRI_DTR = 4;
  localparam int PRI_DSR = 5;
  localparam int PRI_DCD = 6;
  localparam int PRI_RI = 7;
  localparam logic [7:0] UART_OE_MASK = 8'h15;

  // =====================================================================
  // register map
  localparam logic [7:0] REG_FUNC_LO = 8'h00;
  localparam logic [7:0] REG_FUNC_HI = 8'h04;
  localparam logic [7:0] REG_OPTIONS = 8'h08;
  localparam logic [7:0] REG_BIT_PERIOD = 8'h0C;
  localparam logic [7:0] REG_BB_OUT = 8'h10;
  localparam logic [7:0] REG_BB_DIR = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam int OPT_CFG_VALID = 0;
  localparam int OPT_SUSP_PULLDOWN = 1;
  localparam int OPT_REMOTE_WAKE = 2;
  localparam int STAT_SUSPEND = 0;
  localparam int STAT_CONFIGURED = 1;
  localparam int STAT_LINE_DRV = 2;
  localparam int STAT_RESUME = 3;
  localparam int STAT_PRI_IN_LSB = 8;
  localparam int STAT_AUX_IN_LSB = 16;
  localparam logic [2:0] OPTIONS_RST = 3'h0;
  localparam logic [15:0] BIT_PERIOD_RST = 16'h0010;
  localparam logic [9:0] BB_RST = 10'h000;

  // =====================================================================
  // types
  typedef enum logic [3:0] {
    FN_LINE_DRV = 4'b0000,
    FN_PWR_EN = 4'b0001,
    FN_TX_LED = 4'b0010,
    FN_RX_LED = 4'b0011,
    FN_ACT_LED = 4'b0100,
    FN_SUSPEND = 4'b0101,
    FN_CLK_HALF = 4'b0110,
    FN_CLK_QUARTER = 4'b0111,
    FN_CLK_EIGHTH = 4'b1000,
    FN_INPUT_PU = 4'b1001,
    FN_DRIVE_HIGH = 4'b1010,
    FN_DRIVE_LOW = 4'b1011,
    FN_BITBANG = 4'b1100
  } aps_func_t;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_LEAD = 2'b01,
    LD_SEND = 2'b10,
    LD_TRAIL = 2'b11
  } aps_ld_state_t;

endpackage

// [aps_clk_gen.sv]
// Purpose: fractional clock generator for the divided clock outputs
// Assumes: output toggle rate below mclk rate
// Notes: average frequency exact, edges jitter by one mclk period
`timescale 1ns/1ns
module aps_clk_gen
  import aps_pkg::*;
#(
  parameter int OUT_KHZ = HALF_CLK_KHZ
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  output logic clkOut
);

  localparam logic [17:0] INC = 18'(2 * OUT_KHZ);
  localparam logic [17:0] DEN = 18'(MCLK_KHZ);

  typedef struct packed {
    logic [17:0] acc;
    logic clk;
  } aps_clk_state_t;

  aps_clk_state_t s;
  aps_clk_state_t n;
  logic [17:0] sum;

  always_comb begin
    n = s;
    sum = s.acc + INC;
    if (!run) begin
      n.acc = 18'h00000;
      n.clk = 1'b0;
    end else if (sum >= DEN) begin
      n.acc = sum - DEN;
      n.clk = ~s.clk;
    end else begin
      n.acc = sum;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign clkOut = s.clk;

endmodule

// [aps_led_pulse.sv]
// Purpose: stretches activity into a visible active-low led pulse
// Assumes: activity is a level on mclk
// Notes: led stays low for HOLD_CYC cycles after activity ends
`timescale 1ns/1ns
module aps_led_pulse
  import aps_pkg::*;
#(
  parameter int HOLD_CYC = LED_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic activity,
  output logic ledN
);

  localparam int CW = $clog2(HOLD_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic ledN;
  } aps_led_state_t;

  aps_led_state_t s;
  aps_led_state_t n;

  always_comb begin
    n = s;
    if (activity) begin
      n.cnt = CW'(HOLD_CYC);
    end else if (s.cnt != '0) begin
      n.cnt = s.cnt - 1'b1;
    end
    n.ledN = (n.cnt == '0);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s.cnt <= '0;
      s.ledN <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign ledN = s.ledN;

endmodule

// [aps_chk.sv]
// Purpose: port checker for the auxiliary pin function select
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound into the design below
`timescale 1ns/1ns
module aps_chk
  import aps_pkg::*;
#(
  parameter int LED_HOLD_CYC = LED_PULSE_CYC
) (
  input logic mclk,
  input logic rst_n,
  input logic usbSuspend,
  input logic usbResumeReq,
  input logic uartTxPending,
  input logic uartTxBusy,
  input logic uartTxGo,
  input logic uartTxd,
  input logic uartRxd,
  input logic uartRiN,
  input logic uartCtsN,
  input logic uartDsrN,
  input logic uartDcdN,
  input logic [7:0] priPortIn,
  input logic [7:0] priPortOut,
  input logic [7:0] priPortOe,
  input logic [AUX_PINS-1:0] auxOe,
  input logic [AUX_PINS-1:0] auxPullUp,
  input logic [AUX_PINS-1:0] auxPullDown
);
  // ==========
  // properties
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  tx_path_a: assert property ($past(rst_n) |->
    priPortOut[PRI_TXD] == $past(uartTxd) && priPortOe == UART_OE_MASK)
    else $error("txd path or pin directions wrong");
  rx_sync_a: assert property ($past(rst_n) && $past(rst_n, 2) |->
    uartRiN == $past(priPortIn[PRI_RI], 2)
    && uartRxd == $past(priPortIn[PRI_RXD], 2)
    && uartCtsN == $past(priPortIn[PRI_CTS], 2)
    && uartDsrN == $past(priPortIn[PRI_DSR], 2)
    && uartDcdN == $past(priPortIn[PRI_DCD], 2))
    else $error("primary inputs not passed after two edges");
  pull_excl_a: assert property (
    (auxPullUp & auxPullDown) == 10'h000)
    else $error("pin pulled both ways");
  pd_susp_a: assert property (|auxPullDown |-> $past(usbSuspend))
    else $error("pull-down outside suspend");
  reset_dflt_a: assert property ($rose(rst_n) |->
    auxOe == 10'h000 && auxPullUp == 10'h3FF && auxPullDown == 10'h000)
    else $error("aux pins not pulled-up inputs after reset");
  resume_susp_a: assert property (
    usbResumeReq |-> $past(usbSuspend))
    else $error("resume requested while not suspended");
  go_start_a: assert property ($rose(uartTxGo) |->
    $past(uartTxPending) && $past(uartTxPending, 2))
    else $error("transmit released without lead time");
  go_stop_a: assert property ($fell(uartTxGo) |->
    !$past(uartTxBusy) && !$past(uartTxPending))
    else $error("transmit withdrawn during a frame");
endmodule

bind aps_pin_func_select aps_chk #(.LED_HOLD_CYC(LED_HOLD_CYC)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .usbSuspend(usbSuspend),
  .usbResumeReq(usbResumeReq), .uartTxPending(uartTxPending),
  .uartTxBusy(uartTxBusy), .uartTxGo(uartTxGo), .uartTxd(uartTxd),
  .uartRxd(uartRxd), .uartRiN(uartRiN), .uartCtsN(uartCtsN),
  .uartDsrN(uartDsrN), .uartDcdN(uartDcdN), .priPortIn(priPortIn),
  .priPortOut(priPortOut), .priPortOe(priPortOe), .auxOe(auxOe),
  .auxPullUp(auxPullUp), .auxPullDown(auxPullDown)
);

// [aps_uart_model.sv]
// Purpose: serializer model on the line driver link
// Assumes: frames of FRAME cycles, idle line high
// Notes: at most one frame pending; want is only taken while no frame is busy
`timescale 1ns/1ns
module aps_uart_model #(
  parameter int FRAME = 10
) (
  input logic mclk,
  input logic rst_n,
  input logic want,
  input logic uartTxGo,
  output logic uartTxPending,
  output logic uartTxBusy,
  output logic uartTxd
);
  // ==========
  // frame sequencer
  int n;
  assign uartTxd = uartTxBusy ? n[0] : 1'b1;
  always @(posedge mclk) begin
    if (!rst_n) begin
      uartTxPending <= 1'b0;
      uartTxBusy <= 1'b0;
      n <= 0;
    end else if (uartTxBusy) begin
      n <= n + 1;
      if (n == FRAME - 1)
        uartTxBusy <= 1'b0;
    end else if (uartTxPending && uartTxGo) begin
      uartTxPending <= 1'b0;
      uartTxBusy <= 1'b1;
      n <= 0;
    end else if (want) begin
      uartTxPending <= 1'b1;
    end
  end
endmodule

// [aps_pin_func_select_tb_top.sv]
// Purpose: self-checking bench for the auxiliary pin function select
// Assumes: serializer model drives the line driver link
// Notes: pins are sampled on falling edges, away from updates
`timescale 1ns/1ns
module aps_pin_func_select_tb_top
  import aps_pkg::*;
;
  // ==========
  // signals
  logic mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, want = 1'b0;
  logic usbSuspend = 1'b0, usbConfigured = 1'b0, uartRxBusy = 1'b0;
  logic uartRtsN = 1'b1, uartDtrN = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [7:0] priPortIn = 8'hD5, priPortOut, priPortOe, po;
  logic [9:0] auxIn = 10'h3FF, auxOut, auxOe, auxPullUp, auxPullDown;
  logic [9:0] ao, ae, pu, pd;
  logic hreadyout, hresp, usbResumeReq, uartTxGo, uartTxPending, uartTxBusy;
  logic uartTxd, rq, p0, pg, p5;
  int error_cnt = 0, compares = 0, t = 0, nf = 0, r5 = 0, tr, tg, tf, tp;
  int ks[3] = '{HALF_CLK_KHZ, QUARTER_CLK_KHZ, EIGHTH_CLK_KHZ};
  localparam int P = 4;

  aps_pin_func_select #(.LED_HOLD_CYC(4)) dut (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata),
    .usbSuspend(usbSuspend), .usbConfigured(usbConfigured),
    .usbResumeReq(usbResumeReq), .uartTxPending(uartTxPending),
    .uartTxBusy(uartTxBusy), .uartRxBusy(uartRxBusy), .uartTxGo(uartTxGo),
    .uartTxd(uartTxd), .uartRtsN(uartRtsN), .uartDtrN(uartDtrN),
    .uartRxd(), .uartCtsN(), .uartDsrN(), .uartDcdN(), .uartRiN(),
    .priPortIn(priPortIn), .priPortOut(priPortOut), .priPortOe(priPortOe),
    .auxIn(auxIn), .auxOut(auxOut), .auxOe(auxOe),
    .auxPullUp(auxPullUp), .auxPullDown(auxPullDown)
  );
  aps_uart_model #(.FRAME(10)) far (
    .mclk(mclk), .rst_n(rst_n), .want(want), .uartTxGo(uartTxGo),
    .uartTxPending(uartTxPending), .uartTxBusy(uartTxBusy),
    .uartTxd(uartTxd)
  );

  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

  // ==========
  // pin snapshots and edge stamps
  always @(negedge mclk) begin
    ao <= auxOut;
    ae <= auxOe;
    pu <= auxPullUp;
    pd <= auxPullDown;
    po <= priPortOut;
    rq <= usbResumeReq;
    t <= t + 1;
    p0 <= auxOut[0];
    pg <= uartTxGo;
    p5 <= auxOut[5];
    if (auxOut[5] && !p5) r5 <= r5 + 1;
    if (auxOut[0] && !p0) tr <= t;
    // first start bit on the txd pin after the enable pin rose
    if (!priPortOut[0] && po[0] && tg <= tr) tg <= t;
    if (!uartTxGo && pg) tf <= t;
    if (!auxOut[0] && p0) begin
      tp <= t;
      nf <= nf + 1;
    end
  end

  // ==========
  // tasks
  task automatic chk(input string s, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 1'b0, hresp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic summarize;
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge mclk);
    error_cnt++;
    summarize;
  end

  // ==========
  // tests
  initial begin
    logic [31:0] v;
    int d;
    cyc(8);
    rst_n <= 1'b1;
    uartRtsN <= 1'b0;
    uartDtrN <= 1'b0;
    cyc(3);
    chk("oe", 10'h000, ae);
    chk("pu", 10'h3FF, pu);
    chk("priOe", UART_OE_MASK, priPortOe);
    chk("priOut", 8'h01, po);
    bus(1'b0, REG_BIT_PERIOD, 32'h0, v);
    chk("period", {16'h0, BIT_PERIOD_RST}, v);
    bus(1'b0, 8'h40, 32'h0, v);
    chk("unmapped", 32'h0, v);
    wr(REG_FUNC_LO, 32'h5C643210);
    wr(REG_FUNC_HI, 32'hBA);
    wr(REG_OPTIONS, 32'h2);
    bus(1'b0, REG_FUNC_LO, 32'h0, v);
    chk("funcLo", 32'h5C643210, v);
    priPortIn <= 8'h6A;
    usbSuspend <= 1'b1;
    cyc(5);
    chk("oe", 10'h000, ae);
    chk("pd", 10'h3FF, pd);
    chk("pu", 10'h000, pu);
    chk("req", 1'b0, rq);
    usbSuspend <= 1'b0;
    priPortIn <= 8'hD5;
    wr(REG_BIT_PERIOD, P);
    wr(REG_OPTIONS, 32'h1);
    cyc(3);
    chk("oe", 10'h3BF, ae);
    chk("fixed", 2'b01, {ao[9], ao[8]});
    chk("pwr", 1'b1, ao[1]);
    wr(REG_OPTIONS, 32'h7);
    usbConfigured <= 1'b1;
    cyc(3);
    chk("pwr", 1'b0, ao[1]);
    chk("susp", 1'b1, ao[7]);
    usbSuspend <= 1'b1;
    cyc(3);
    chk("pwr", 1'b1, ao[1]);
    chk("susp", 1'b0, ao[7]);
    chk("pin6", 2'b01, {pu[6], pd[6]});
    priPortIn <= 8'h6A;
    cyc(5);
    chk("req", 1'b1, rq);
    usbSuspend <= 1'b0;
    priPortIn <= 8'hD5;
    cyc(3);
    chk("req", 1'b0, rq);
    chk("pin6", 2'b10, {pu[6], pd[6]});
    for (int i = 0; i < 3; i++) begin
      wr(REG_FUNC_LO, 32'h5C043210 | ((32'h6 + i) << 20));
      cyc(4);
      d = r5;
      cyc(1000);
      d = r5 - d - 1000 * ks[i] / MCLK_KHZ;
      chk("clk", 1'b1, d >= -1 && d <= 1);
    end
    usbSuspend <= 1'b1;
    cyc(3);
    d = r5;
    cyc(200);
    chk("clkStop", d, r5);
    usbSuspend <= 1'b0;
    d = nf;
    want <= 1'b1;
    cyc(1);
    want <= 1'b0;
    cyc(12);
    chk("txLeds", 3'b010, {ao[4], ao[3], ao[2]});
    cyc(60);
    chk("lead", 1'b1, tg - tr == P || tg - tr == P + 1);
    chk("trail", 1'b1, tp - tf == P || tp - tf == P + 1);
    chk("leds", 3'b111, {ao[4], ao[3], ao[2]});
    d = nf;
    want <= 1'b1;
    cyc(25);
    want <= 1'b0;
    cyc(60);
    chk("falls", d + 1, nf);
    uartRxBusy <= 1'b1;
    cyc(3);
    chk("rxLeds", 3'b001, {ao[4], ao[3], ao[2]});
    uartRxBusy <= 1'b0;
    cyc(8);
    chk("leds", 3'b111, {ao[4], ao[3], ao[2]});
    wr(REG_FUNC_LO, 32'h5C64DCA0);
    wr(REG_BB_DIR, 32'h40);
    wr(REG_BB_OUT, 32'h40);
    cyc(2);
    chk("barred", 6'h38, {pu[3:1], ae[3:1]});
    chk("bbOut", 2'b11, {ae[6], ao[6]});
    wr(REG_BB_DIR, 32'h0);
    auxIn <= 10'h2BF;
    cyc(4);
    bus(1'b0, REG_STATUS, 32'h0, v);
    chk("bbIn", 1'b0, v[STAT_AUX_IN_LSB + 6]);
    chk("status", 13'h1802, v[12:0]);
    summarize;
  end
endmodule
